// >>> twb_pkg.sv
package twb_pkg;

  // ------------------------------------------------------------
  // Register word offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_SHARED_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MASTER_CTRL = 8'h04;
  localparam logic [7:0] ADDR_MASTER_STAT = 8'h08;
  localparam logic [7:0] ADDR_MASTER_BAUD = 8'h0C;
  localparam logic [7:0] ADDR_MASTER_ADDR = 8'h10;
  localparam logic [7:0] ADDR_MASTER_CMD = 8'h14;
  localparam logic [7:0] ADDR_MASTER_DATA = 8'h18;
  localparam logic [7:0] ADDR_SLAVE_CTRL = 8'h1C;
  localparam logic [7:0] ADDR_SLAVE_ADDR = 8'h20;
  localparam logic [7:0] ADDR_SLAVE_DATA = 8'h24;
  localparam logic [7:0] ADDR_SLAVE_STAT = 8'h28;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int MCTRL_ENABLE_BIT = 0;
  localparam int MCTRL_TIMEOUT_LSB = 2;
  localparam int MSTAT_BUSY_BIT = 2;
  localparam int MSTAT_ERR_BIT = 3;
  localparam int MSTAT_NACK_BIT = 4;
  localparam int SCTRL_ENABLE_BIT = 0;
  localparam logic [7:0] BAUD_RESET = 8'h0F;
  localparam logic [4:0] SHARED_CTRL_RESET = 5'h00;

  // Inactive-bus timeout limits, counted in quarter-bit ticks
  localparam logic [7:0] TIMEOUT_TICKS_1 = 8'h32;
  localparam logic [7:0] TIMEOUT_TICKS_2 = 8'h64;
  localparam logic [7:0] TIMEOUT_TICKS_3 = 8'hC8;

  // ------------------------------------------------------------
  // Master commands
  // ------------------------------------------------------------
  localparam logic [2:0] CMD_START = 3'h1;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_READ_ACK = 3'h3;
  localparam logic [2:0] CMD_READ_NACK = 3'h4;
  localparam logic [2:0] CMD_STOP = 3'h5;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_UNKNOWN = 2'h0,
    BUS_IDLE = 2'h1,
    BUS_OWNER = 2'h2,
    BUS_BUSY = 2'h3
  } bus_state_e;

  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_START = 2'h1,
    M_BYTE = 2'h3,
    M_STOP = 2'h2
  } mst_e;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ADDR = 3'h1,
    S_ACK = 3'h3,
    S_RX = 3'h2,
    S_TX = 3'h6,
    S_TXACK = 3'h7
  } slv_e;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } line_s;

  function automatic logic [7:0] timeout_limit(input logic [1:0] sel);
    case (sel)
      2'h1: timeout_limit = TIMEOUT_TICKS_1;
      2'h2: timeout_limit = TIMEOUT_TICKS_2;
      default: timeout_limit = TIMEOUT_TICKS_3;
    endcase
  endfunction

endpackage

// >>> line_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module line_monitor
  import twb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output line_s line
);

  typedef struct packed {
    logic s1_scl;
    logic s1_sda;
    logic s2_scl;
    logic s2_sda;
    logic p_scl;
    logic p_sda;
  } mon_s;

  mon_s mon_reg;
  mon_s mon_next;

  // Three flops per line; the second stage feeds the logic and the third only the edge detection
  always_comb begin
    mon_next = mon_reg;
    mon_next.s1_scl = scl_in;
    mon_next.s1_sda = sda_in;
    mon_next.s2_scl = mon_reg.s1_scl;
    mon_next.s2_sda = mon_reg.s1_sda;
    mon_next.p_scl = mon_reg.s2_scl;
    mon_next.p_sda = mon_reg.s2_sda;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mon_reg <= '1;
    end else begin
      mon_reg <= mon_next;
    end
  end

  always_comb begin
    line.scl = mon_reg.s2_scl;
    line.sda = mon_reg.s2_sda;
    line.scl_rise = mon_reg.s2_scl & ~mon_reg.p_scl;
    line.scl_fall = ~mon_reg.s2_scl & mon_reg.p_scl;
    // SDA edge while SCL stays high
    line.start = mon_reg.p_scl & mon_reg.s2_scl & mon_reg.p_sda &
                 ~mon_reg.s2_sda;
    line.stop = mon_reg.p_scl & mon_reg.s2_scl & ~mon_reg.p_sda &
                mon_reg.s2_sda;
  end

endmodule
`default_nettype wire

// >>> baud_gen.sv
`timescale 1ns/1ns
`default_nettype none
module baud_gen
  import twb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic enable,
  input wire logic [7:0] period,
  output logic tick
);

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } baud_s;

  baud_s bg_reg;
  baud_s bg_next;

  // One tick every period+1 cycles, a quarter of an SCL bit
  always_comb begin
    bg_next = bg_reg;
    bg_next.tick = 1'b0;
    if (!enable) begin
      bg_next.cnt = 8'h00;
    end else if (bg_reg.cnt >= period) begin
      bg_next.cnt = 8'h00;
      bg_next.tick = 1'b1;
    end else begin
      bg_next.cnt = bg_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bg_reg <= '0;
    end else begin
      bg_reg <= bg_next;
    end
  end

  assign tick = bg_reg.tick;

endmodule
`default_nettype wire

// >>> two_wire_bus_controller.sv
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - master enable bit starts master; timeout selectable
// - writing idle to bus state forces idle
// - detected STOP makes bus state idle
// - slave starts with own address and enable
// - lines only pulled low or released
// - START is SDA fall while SCL high
// - STOP is SDA rise while SCL high
// - START without preceding STOP is repeated START
// - SDA changes only while SCL low
// - eight bits MSB first plus acknowledge
// - ACK pulls SDA low on ninth clock
// - unmatched slave releases lines, awaits START
// - one address packet per START
// - direction bit selects who sends data
// - data packets nine bits, any number
// - no write after NACK; master must stop
// - read continues only after ACK; NACK last
// - combined transfers joined by repeated START
// - devices stretch SCL low; others wait
module two_wire_bus_controller
  import twb_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE_N,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N
);

  typedef struct packed {
    logic [4:0] shared_ctrl;
    logic m_enable;
    logic [1:0] m_timeout_sel;
    logic [7:0] m_baud;
    logic [7:0] m_addr;
    logic [7:0] m_txdata;
    mst_e m_st;
    logic [1:0] m_phase;
    logic [3:0] m_cnt;
    logic [8:0] m_sh;
    logic [8:0] m_in;
    logic m_rd;
    logic [7:0] m_rxdata;
    logic m_nack;
    logic m_err;
    bus_state_e bus_state;
    logic m_scl_low;
    logic m_sda_low;
    logic [7:0] m_to;
    logic s_enable;
    logic [6:0] s_addr;
    logic [7:0] s_txdata;
    logic s_tx_valid;
    slv_e s_st;
    logic [3:0] s_cnt;
    logic [7:0] s_sh;
    logic s_dir;
    logic [7:0] s_rxdata;
    logic s_ready;
    logic s_addressed;
    logic s_sda_low;
    logic s_scl_low;
    logic wb_ack;
    logic [31:0] wb_dat;
  } ctl_s;

  ctl_s ctl_reg;
  ctl_s ctl_next;
  line_s line;
  logic tick;
  logic wr;
  logic rd;
  logic [7:0] wd;

  // ------------------------------------------------------------
  // Line sampling and bit-rate tick
  // ------------------------------------------------------------
  line_monitor u_line_monitor (
    .clk(CLK_SYS),
    .nrst(NRST),
    .scl_in(SCL_I),
    .sda_in(SDA_I),
    .line(line)
  );

  baud_gen u_baud_gen (
    .clk(CLK_SYS),
    .nrst(NRST),
    .enable(ctl_reg.m_enable),
    .period(ctl_reg.m_baud),
    .tick(tick)
  );

  // Side effects land at the edge where the master sees ack
  assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & ctl_reg.wb_ack & WB_SEL_I[0];
  assign rd = WB_CYC_I & WB_STB_I & ~WB_WE_I & ctl_reg.wb_ack;
  assign wd = WB_DAT_I[7:0];

  always_comb begin
    ctl_next = ctl_reg;

    // ----------------------------------------------------------
    // Wishbone slave: ack one cycle after the request
    // ----------------------------------------------------------
    ctl_next.wb_ack = WB_CYC_I & WB_STB_I & ~ctl_reg.wb_ack;
    if (WB_CYC_I && WB_STB_I && !ctl_reg.wb_ack) begin
      ctl_next.wb_dat = 32'h0000_0000;
      case (WB_ADR_I)
        ADDR_SHARED_CTRL: ctl_next.wb_dat[4:0] = ctl_reg.shared_ctrl;
        ADDR_MASTER_CTRL: begin
          ctl_next.wb_dat[MCTRL_ENABLE_BIT] = ctl_reg.m_enable;
          ctl_next.wb_dat[MCTRL_TIMEOUT_LSB+:2] = ctl_reg.m_timeout_sel;
        end
        ADDR_MASTER_STAT: begin
          ctl_next.wb_dat[1:0] = ctl_reg.bus_state;
          ctl_next.wb_dat[MSTAT_BUSY_BIT] = (ctl_reg.m_st != M_IDLE);
          ctl_next.wb_dat[MSTAT_ERR_BIT] = ctl_reg.m_err;
          ctl_next.wb_dat[MSTAT_NACK_BIT] = ctl_reg.m_nack;
        end
        ADDR_MASTER_BAUD: ctl_next.wb_dat[7:0] = ctl_reg.m_baud;
        ADDR_MASTER_ADDR: ctl_next.wb_dat[7:0] = ctl_reg.m_addr;
        ADDR_MASTER_DATA: ctl_next.wb_dat[7:0] = ctl_reg.m_rxdata;
        ADDR_SLAVE_CTRL: ctl_next.wb_dat[SCTRL_ENABLE_BIT] = ctl_reg.s_enable;
        ADDR_SLAVE_ADDR: ctl_next.wb_dat[6:0] = ctl_reg.s_addr;
        ADDR_SLAVE_DATA: ctl_next.wb_dat[7:0] = ctl_reg.s_rxdata;
        ADDR_SLAVE_STAT: begin
          ctl_next.wb_dat[3:0] = {ctl_reg.s_tx_valid, ctl_reg.s_ready,
                                  ctl_reg.s_dir, ctl_reg.s_addressed};
        end
        default: ctl_next.wb_dat = 32'h0000_0000;
      endcase
    end

    // Register writes come first so engine events set later win
    if (rd && WB_ADR_I == ADDR_SLAVE_DATA) begin
      ctl_next.s_ready = 1'b0;
    end
    if (wr) begin
      case (WB_ADR_I)
        ADDR_SHARED_CTRL: ctl_next.shared_ctrl = wd[4:0];
        ADDR_MASTER_CTRL: begin
          ctl_next.m_enable = wd[MCTRL_ENABLE_BIT];
          ctl_next.m_timeout_sel = wd[MCTRL_TIMEOUT_LSB+:2];
        end
        ADDR_MASTER_STAT: begin
          if (wd[1:0] == BUS_IDLE && ctl_reg.m_enable) begin
            ctl_next.bus_state = BUS_IDLE;
          end
          if (wd[MSTAT_ERR_BIT]) begin
            ctl_next.m_err = 1'b0;
          end
        end
        ADDR_MASTER_BAUD: ctl_next.m_baud = wd;
        ADDR_MASTER_ADDR: ctl_next.m_addr = wd;
        ADDR_MASTER_DATA: ctl_next.m_txdata = wd;
        ADDR_MASTER_CMD: begin
          if (ctl_reg.m_st != M_IDLE || !ctl_reg.m_enable) begin
            ctl_next.m_err = 1'b1;
          end else begin
            ctl_next.m_phase = 2'h0;
            ctl_next.m_cnt = 4'h0;
            case (wd[2:0])
              CMD_START: begin
                // Idle bus gives START, own bus a repeated START
                if (ctl_reg.bus_state == BUS_IDLE ||
                    ctl_reg.bus_state == BUS_OWNER) begin
                  ctl_next.m_st = M_START;
                  ctl_next.m_sh = {ctl_reg.m_addr, 1'b1};
                  ctl_next.m_rd = 1'b0;
                  ctl_next.m_nack = 1'b0;
                end else begin
                  ctl_next.m_err = 1'b1;
                end
              end
              CMD_WRITE: begin
                if (ctl_reg.m_nack || ctl_reg.bus_state != BUS_OWNER) begin
                  ctl_next.m_err = 1'b1;
                end else begin
                  ctl_next.m_st = M_BYTE;
                  ctl_next.m_sh = {ctl_reg.m_txdata, 1'b1};
                  ctl_next.m_rd = 1'b0;
                end
              end
              CMD_READ_ACK, CMD_READ_NACK: begin
                if (ctl_reg.m_nack || ctl_reg.bus_state != BUS_OWNER) begin
                  ctl_next.m_err = 1'b1;
                end else begin
                  ctl_next.m_st = M_BYTE;
                  // Master answers the last byte with NACK
                  ctl_next.m_sh = {8'hFF, wd[2:0] == CMD_READ_NACK};
                  ctl_next.m_rd = 1'b1;
                end
              end
              CMD_STOP: begin
                if (ctl_reg.bus_state == BUS_OWNER) begin
                  ctl_next.m_st = M_STOP;
                end else begin
                  ctl_next.m_err = 1'b1;
                end
              end
              default: ctl_next.m_err = 1'b1;
            endcase
          end
        end
        ADDR_SLAVE_CTRL: ctl_next.s_enable = wd[SCTRL_ENABLE_BIT];
        ADDR_SLAVE_ADDR: ctl_next.s_addr = wd[6:0];
        ADDR_SLAVE_DATA: begin
          ctl_next.s_txdata = wd;
          ctl_next.s_tx_valid = 1'b1;
        end
        default: ;
      endcase
    end

    // ----------------------------------------------------------
    // Master engine: four ticks per bit, SDA moves in phase 0 except for START (phase 2) and the STOP and post-acknowledge releases (phase 3)
    // ----------------------------------------------------------
    if (tick) begin
      unique case (ctl_reg.m_st)
        M_IDLE: ;
        M_START: begin
          unique case (ctl_reg.m_phase)
            2'h0: ctl_next.m_sda_low = 1'b0;
            2'h1: ctl_next.m_scl_low = 1'b0;
            2'h2: begin
              // Wait out any stretch, then SDA falls under high SCL
              if (line.scl && line.sda) begin
                ctl_next.m_sda_low = 1'b1;
              end
            end
            2'h3: begin
              // Keep SCL high until the monitor has seen our own START,
              // or it would take the START for another master's
              if (!line.sda) begin
                ctl_next.m_scl_low = 1'b1;
                ctl_next.m_st = M_BYTE;
              end
            end
          endcase
          if ((ctl_reg.m_phase != 2'h2 || (line.scl && line.sda)) &&
              (ctl_reg.m_phase != 2'h3 || !line.sda)) begin
            ctl_next.m_phase = ctl_reg.m_phase + 2'h1;
          end
        end
        M_BYTE: begin
          unique case (ctl_reg.m_phase)
            2'h0: ctl_next.m_sda_low = ~ctl_reg.m_sh[8];
            2'h1: ctl_next.m_scl_low = 1'b0;
            2'h2: begin
              if (line.scl) begin
                ctl_next.m_in = {ctl_reg.m_in[7:0], line.sda};
                // Released bit read back low: another master won
                if (!ctl_reg.m_rd && ctl_reg.m_cnt != 4'h8 &&
                    !ctl_reg.m_sda_low && !line.sda) begin
                  ctl_next.m_st = M_IDLE;
                  ctl_next.m_sda_low = 1'b0;
                  ctl_next.m_scl_low = 1'b0;
                  ctl_next.m_err = 1'b1;
                  ctl_next.bus_state = BUS_BUSY;
                end
              end
            end
            2'h3: begin
              ctl_next.m_scl_low = 1'b1;
              ctl_next.m_sh = {ctl_reg.m_sh[7:0], 1'b1};
              ctl_next.m_cnt = ctl_reg.m_cnt + 4'h1;
              if (ctl_reg.m_cnt == 4'h8) begin
                // Ninth bit is the acknowledge: low means ACK
                ctl_next.m_st = M_IDLE;
                ctl_next.m_sda_low = 1'b0;
                ctl_next.m_nack = ctl_reg.m_in[0];
                ctl_next.m_rxdata = ctl_reg.m_in[8:1];
                ctl_next.m_cnt = 4'h0;
              end
            end
          endcase
          if (ctl_reg.m_phase != 2'h2 || line.scl) begin
            ctl_next.m_phase = ctl_reg.m_phase + 2'h1;
          end
        end
        M_STOP: begin
          unique case (ctl_reg.m_phase)
            2'h0: ctl_next.m_sda_low = 1'b1;
            2'h1: ctl_next.m_scl_low = 1'b0;
            2'h2: ;
            2'h3: begin
              ctl_next.m_sda_low = 1'b0;
              ctl_next.m_st = M_IDLE;
            end
          endcase
          if (ctl_reg.m_phase != 2'h2 || line.scl) begin
            ctl_next.m_phase = ctl_reg.m_phase + 2'h1;
          end
        end
      endcase
    end

    // ----------------------------------------------------------
    // Bus state monitor
    // ----------------------------------------------------------
    if (ctl_reg.m_enable) begin
      if (line.stop) begin
        ctl_next.bus_state = BUS_IDLE;
      end else if (line.start) begin
        if (ctl_reg.m_st == M_START) begin
          ctl_next.bus_state = BUS_OWNER;
        end else if (ctl_reg.bus_state != BUS_OWNER) begin
          ctl_next.bus_state = BUS_BUSY;
        end
      end
      // Inactive-bus timeout only with a nonzero selection
      if (ctl_reg.bus_state == BUS_BUSY && ctl_reg.m_timeout_sel != 2'h0 &&
          line.scl && line.sda) begin
        if (tick) begin
          ctl_next.m_to = ctl_reg.m_to + 8'h01;
          if (ctl_reg.m_to >= timeout_limit(ctl_reg.m_timeout_sel)) begin
            ctl_next.bus_state = BUS_IDLE;
            ctl_next.m_to = 8'h00;
          end
        end
      end else begin
        ctl_next.m_to = 8'h00;
      end
    end else begin
      // A disabled master forgets the bus and lets go of it
      ctl_next.bus_state = BUS_UNKNOWN;
      ctl_next.m_st = M_IDLE;
      ctl_next.m_scl_low = 1'b0;
      ctl_next.m_sda_low = 1'b0;
      ctl_next.m_to = 8'h00;
    end

    // ----------------------------------------------------------
    // Slave engine, driven by SCL edges seen on the line
    // ----------------------------------------------------------
    if (!ctl_reg.s_enable || line.stop) begin
      ctl_next.s_st = S_IDLE;
      ctl_next.s_sda_low = 1'b0;
      ctl_next.s_scl_low = 1'b0;
      ctl_next.s_addressed = 1'b0;
    end else if (line.start) begin
      ctl_next.s_st = S_ADDR;
      ctl_next.s_cnt = 4'h0;
      ctl_next.s_sda_low = 1'b0;
      ctl_next.s_scl_low = 1'b0;
      ctl_next.s_addressed = 1'b0;
    end else begin
      unique case (ctl_reg.s_st)
        S_IDLE: ;
        S_ADDR, S_RX: begin
          if (line.scl_rise) begin
            ctl_next.s_sh = {ctl_reg.s_sh[6:0], line.sda};
            ctl_next.s_cnt = ctl_reg.s_cnt + 4'h1;
          end else if (line.scl_fall && ctl_reg.s_cnt == 4'h8) begin
            if (ctl_reg.s_st == S_RX) begin
              ctl_next.s_rxdata = ctl_reg.s_sh;
              ctl_next.s_ready = 1'b1;
              ctl_next.s_sda_low = 1'b1;
              ctl_next.s_st = S_ACK;
            end else if (ctl_reg.s_sh[7:1] == ctl_reg.s_addr) begin
              ctl_next.s_addressed = 1'b1;
              ctl_next.s_dir = ctl_reg.s_sh[0];
              ctl_next.s_sda_low = 1'b1;
              ctl_next.s_st = S_ACK;
            end else begin
              ctl_next.s_st = S_IDLE;
            end
          end
        end
        S_ACK: begin
          if (line.scl_fall || ctl_reg.s_scl_low) begin
            ctl_next.s_cnt = 4'h0;
            if (!ctl_reg.s_dir) begin
              ctl_next.s_sda_low = 1'b0;
              ctl_next.s_st = S_RX;
            end else if (ctl_reg.s_tx_valid) begin
              ctl_next.s_sh = ctl_reg.s_txdata;
              ctl_next.s_tx_valid = 1'b0;
              ctl_next.s_sda_low = ~ctl_reg.s_txdata[7];
              ctl_next.s_scl_low = 1'b0;
              ctl_next.s_st = S_TX;
            end else begin
              // Nothing to send yet: hold SCL low until software loads
              ctl_next.s_sda_low = 1'b0;
              ctl_next.s_scl_low = 1'b1;
            end
          end
        end
        S_TX: begin
          if (line.scl_rise) begin
            ctl_next.s_cnt = ctl_reg.s_cnt + 4'h1;
          end else if (line.scl_fall) begin
            if (ctl_reg.s_cnt == 4'h8) begin
              ctl_next.s_sda_low = 1'b0;
              ctl_next.s_st = S_TXACK;
            end else begin
              ctl_next.s_sh = {ctl_reg.s_sh[6:0], 1'b0};
              ctl_next.s_sda_low = ~ctl_reg.s_sh[6];
            end
          end
        end
        S_TXACK: begin
          if (line.scl_rise && line.sda) begin
            ctl_next.s_st = S_IDLE;
          end else if (line.scl_fall) begin
            ctl_next.s_scl_low = 1'b1;
            ctl_next.s_st = S_ACK;
          end
        end
        default: ctl_next.s_st = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ctl_reg <= '0;
      ctl_reg.shared_ctrl <= SHARED_CTRL_RESET;
      ctl_reg.m_baud <= BAUD_RESET;
      ctl_reg.bus_state <= BUS_UNKNOWN;
      ctl_reg.m_st <= M_IDLE;
      ctl_reg.s_st <= S_IDLE;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // ------------------------------------------------------------
  // Pins: open drain, the driven level is always low
  // ------------------------------------------------------------
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE_N = ~(ctl_reg.m_scl_low | ctl_reg.s_scl_low);
  assign SDA_OE_N = ~(ctl_reg.m_sda_low | ctl_reg.s_sda_low);
  assign WB_ACK_O = ctl_reg.wb_ack;
  assign WB_DAT_O = ctl_reg.wb_dat;

endmodule
`default_nettype wire

// >>> twb_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module twb_assertions (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic SCL_I,
  input wire logic SCL_O,
  input wire logic SCL_OE_N,
  input wire logic SDA_O,
  input wire logic SDA_OE_N
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  a_ack_prompt: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
    |=> WB_ACK_O) else $error("ack late");
  a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack unasked");
  a_read_upper: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
    else $error("upper bits set");
  a_unmapped_zero: assert property (WB_ACK_O && !WB_WE_I
    && WB_ADR_I > 8'h28 |-> WB_DAT_O == 32'h0) else $error("hole data");
  a_pins_low_only: assert property (!SCL_O && !SDA_O)
    else $error("pin driven high");
  a_reset_release: assert property (disable iff (1'h0) !NRST
    |-> SCL_OE_N && SDA_OE_N) else $error("lines held in reset");
  a_start_form: assert property ($fell(SDA_OE_N) && SCL_OE_N |-> SCL_I)
    else $error("start with scl low");
  a_stop_form: assert property ($rose(SDA_OE_N) && SCL_OE_N |-> SCL_I)
    else $error("stop with scl low");
  a_stretch_wait: assert property (SCL_OE_N && !SCL_I |=> SCL_OE_N)
    else $error("stretch ignored");
endmodule
`default_nettype wire

// >>> twb_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
module twb_slave_model #(
  parameter logic [6:0] ADR = 7'h5A,
  parameter logic [7:0] TXB = 8'hA5
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic stretch,
  output logic sda_oe_n,
  output logic scl_oe_n
);
  int n = 0;
  int m;
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  logic sel = 1'h0;
  logic rd = 1'h0;
  initial sda_oe_n = 1'h1;
  initial scl_oe_n = 1'h1;
  always @(negedge sda) if (scl) begin
    n = 0;
    sel = 1'h0;
  end
  always @(posedge sda) if (scl) sel = 1'h0;
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    n = n + 1;
    if (n == 8) begin
      sel = sh[7:1] == ADR;
      rd = sh[0];
    end
    if (n > 9 && n % 9 == 8) rx = sh;
    if (rd && n > 9 && n % 9 == 0 && sda) sel = 1'h0;
  end
  // Unselected or idle: the line is left to the pull-up
  always @(negedge scl) begin
    m = n % 9;
    sda_oe_n = 1'h1;
    if (sel && rd && n > 8 && m < 8) sda_oe_n = TXB[7-m];
    if (sel && (n == 8 || (!rd && m == 8))) sda_oe_n = 1'h0;
  end
  always @(negedge scl) if (stretch) begin
    scl_oe_n = 1'h0;
    #160 scl_oe_n = 1'h1;
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import twb_pkg::*;
;
  typedef struct {
    logic [31:0] v;
    logic [31:0] m;
    logic [7:0] a;
  } exp_s;
  exp_s q[$];
  exp_s e;
  logic clk, nrst, cyc, stb, we, ack, stretch, scl_oe_n, sda_oe_n;
  logic p_scl, p_sda;
  logic [7:0] adr, d;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, r;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  wire logic scl = scl_oe_n & p_scl;
  wire logic sda = sda_oe_n & p_sda;
  two_wire_bus_controller u_two_wire_bus_controller (.CLK_SYS(clk),
    .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .SCL_I(scl), .SCL_O(), .SCL_OE_N(scl_oe_n),
    .SDA_I(sda), .SDA_O(), .SDA_OE_N(sda_oe_n));
  twb_slave_model u_twb_slave_model (.scl(scl), .sda(sda),
    .stretch(stretch), .sda_oe_n(p_sda), .scl_oe_n(p_scl));
  task automatic check(input logic [31:0] g, x, input logic [7:0] a);
    compares++;
    if (g !== x) begin
      fail_count++;
      $display("BAD reg %h exp %h got %h", a, x, g);
    end
  endtask
  task automatic results();
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, x);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, x};
    do begin
      @(posedge clk);
    end while (ack !== 1'h1);
    r = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, x);
    wb(1'h1, a, x);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v, m);
    q.push_back('{v, m, a});
    wb(1'h0, a, 8'h00);
  endtask
  task automatic cmd(input logic [7:0] c);
    int k;
    k = 0;
    wr(ADDR_MASTER_CMD, c);
    do begin
      wb(1'h0, ADDR_MASTER_STAT, 8'h00);
      k++;
    end while (r[MSTAT_BUSY_BIT] !== 1'h0 && k < 900);
    if (k == 900) fail_count++;
  endtask
  // Mid-cycle look keeps a poll read's ack apart from the next note
  always @(negedge clk) if (ack === 1'h1 && !we && q.size() > 0) begin
    e = q.pop_front();
    check(rdat & e.m, e.v, e.a);
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    {nrst, cyc, stb, we, stretch, adr, wdat} = '0;
    sel = 4'hF;
    d = 8'($urandom(32'hDAAE));
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    rd(ADDR_MASTER_BAUD, 32'h0F, 32'hFFFFFFFF);
    wr(8'h40, 8'hFF);
    rd(8'h40, 32'h0, 32'hFFFFFFFF);
    wr(ADDR_SHARED_CTRL, 8'h1E);
    rd(ADDR_SHARED_CTRL, 32'h1E, 32'hFF);
    wr(ADDR_MASTER_BAUD, 8'h01);
    wr(ADDR_SLAVE_ADDR, 8'h21);
    wr(ADDR_SLAVE_CTRL, 8'h01);
    wr(ADDR_MASTER_CTRL, 8'h01);
    rd(ADDR_MASTER_STAT, 32'h0, 32'h3);
    wr(ADDR_MASTER_STAT, 8'h01);
    rd(ADDR_MASTER_STAT, 32'h1, 32'h3);
    wr(ADDR_MASTER_ADDR, 8'hB4);
    cmd(CMD_START);
    rd(ADDR_MASTER_STAT, 32'h2, 32'h13);
    rd(ADDR_SLAVE_STAT, 32'h0, 32'h1);
    wr(ADDR_MASTER_DATA, d);
    cmd(CMD_WRITE);
    check({24'h0, u_twb_slave_model.rx}, {24'h0, d}, 8'h5A);
    stretch <= 1'h1;
    wr(ADDR_MASTER_ADDR, 8'hB5);
    cmd(CMD_START);
    cmd(CMD_READ_ACK);
    cmd(CMD_READ_NACK);
    rd(ADDR_MASTER_DATA, 32'hA5, 32'hFF);
    cmd(CMD_STOP);
    stretch <= 1'h0;
    rd(ADDR_MASTER_STAT, 32'h1, 32'h3);
    d = 8'($urandom);
    wr(ADDR_MASTER_ADDR, 8'h42);
    cmd(CMD_START);
    wr(ADDR_MASTER_DATA, d);
    cmd(CMD_WRITE);
    cmd(CMD_STOP);
    rd(ADDR_SLAVE_DATA, {24'h0, d}, 32'hFF);
    wr(ADDR_MASTER_ADDR, 8'h66);
    cmd(CMD_START);
    rd(ADDR_MASTER_STAT, 32'h12, 32'h13);
    cmd(CMD_WRITE);
    rd(ADDR_MASTER_STAT, 32'h8, 32'h8);
    cmd(CMD_STOP);
    results();
  end
endmodule
bind two_wire_bus_controller twb_assertions u_twb_assertions (
  .CLK_SYS(CLK_SYS), .NRST(NRST), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SCL_I(SCL_I), .SCL_O(SCL_O),
  .SCL_OE_N(SCL_OE_N), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N));
`default_nettype wire
